// *** rtl/bpfs_pkg.sv ***
// Package of constants and types for the boot pin function select block.
package bpfs_pkg;
    localparam int NUM_PINS = 13;
    localparam int SEL_W = 3;
    // Pin indices.
    localparam int PIN_WAKE_IN = 0;
    localparam int PIN_SLEEP_STATE = 1;
    localparam int PIN_LED_A = 2;
    localparam int PIN_LED_B = 3;
    localparam int PIN_HOST_WAKE = 4;
    localparam int PIN_TX = 6;
    localparam int PIN_RX = 7;
    localparam int PIN_RTS = 8;
    localparam int PIN_CTS = 9;
    // Function codes held in each pin selector.
    localparam logic [2:0] FN_IN_NOPULL = 3'h0;
    localparam logic [2:0] FN_IN_PULLUP = 3'h1;
    localparam logic [2:0] FN_GPIO = 3'h2;
    localparam logic [2:0] FN_SPECIAL = 3'h3;
    // Host serial link default rate and its bit time at 125 MHz.
    localparam int CLK_HZ = 125000000;
    localparam int DEFAULT_BAUD = 115200;
    localparam int DEFAULT_BIT_CYCLES = CLK_HZ / DEFAULT_BAUD;
    // Reset function of each pin not routed at boot, index 12 down to 0; bpfs_top resets pins 1 and 6 to 9 unpulled.
    localparam logic [38:0] RESET_FN = {
        FN_IN_PULLUP, FN_IN_PULLUP, FN_IN_PULLUP, FN_IN_NOPULL, FN_SPECIAL,
        FN_IN_NOPULL, FN_SPECIAL, FN_IN_PULLUP, FN_IN_PULLUP, FN_IN_PULLUP,
        FN_IN_PULLUP, FN_SPECIAL, FN_IN_NOPULL};
    typedef enum logic [1:0] {BPFS_BOOTING, BPFS_RUN} bpfs_state_t;
endpackage

// *** rtl/bpfs_pin_sel.sv ***
// One pin's function selector with its pad control.
`timescale 1ns/1ps
`default_nettype none
module bpfs_pin_sel #(
    parameter logic [2:0] RESET_FN = 3'h1,
    parameter logic [2:0] BOOT_FN = 3'h1
) (
    input wire logic clk_sys,        // System clock.
    input wire logic nrst,           // Synchronous reset, active low.
    input wire logic ce,             // Clock enable.
    input wire logic boot_done,      // Boot completion strobe.
    input wire logic cfg_we,         // Decoded configuration write for this pin.
    input wire logic [2:0] cfg_fn,   // Function code to load.
    input wire logic cfg_dout,       // GPIO output value to load.
    input wire logic cfg_oe,         // GPIO drive enable to load.
    input wire logic spec_out,       // Special function output level.
    input wire logic spec_drive,     // Special function drives the pin.
    output logic [2:0] fn,           // Current function code.
    output logic pad_out,            // Pad output level.
    output logic pad_oe_n,           // Pad output enable, low drives.
    output logic pad_pullup          // Pad pull-up enable.
);
    logic [2:0] fn_r, fn_nxt;
    logic dout_r, dout_nxt, oe_r, oe_nxt;
    logic out_r, out_nxt, oen_r, oen_nxt;

    always_comb begin
        fn_nxt = fn_r;
        dout_nxt = dout_r;
        oe_nxt = oe_r;
        if (boot_done) begin
            fn_nxt = BOOT_FN;
        end
        if (cfg_we) begin
            fn_nxt = cfg_fn;
            dout_nxt = cfg_dout;
            oe_nxt = cfg_oe;
        end
        out_nxt = 1'b0;
        oen_nxt = 1'b1;
        if (fn_nxt == bpfs_pkg::FN_GPIO) begin
            out_nxt = dout_nxt;
            oen_nxt = ~oe_nxt;
        end else if (fn_nxt == bpfs_pkg::FN_SPECIAL) begin
            out_nxt = spec_out;
            oen_nxt = ~spec_drive;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            fn_r <= RESET_FN;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            out_r <= 1'b0;
            oen_r <= 1'b1;
        end else if (ce) begin
            fn_r <= fn_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            out_r <= out_nxt;
            oen_r <= oen_nxt;
        end
    end

    assign fn = fn_r;
    assign pad_out = out_r;
    assign pad_oe_n = oen_r;
    assign pad_pullup = (fn_r == bpfs_pkg::FN_IN_PULLUP);
endmodule
`default_nettype wire

// *** rtl/bpfs_top.sv ***
// Pin function multiplexer for general pins 0 to 12.
//
// Summary of operation
// - after boot, pin 1 shows sleep state.
// - sleep indicator low active, high asleep.
// - after boot, pin 6 is serial transmit.
// - after boot, pin 7 is receive, no pull.
// - after boot, pin 8 is request-to-send output.
// - after boot, pin 9 is clear-to-send input.
// - pin 0 unpulled input; wake input when configured.
// - pins 2, 3 pulled up; LED when configured.
// - pin 4 pulled up; host wake when configured.
// - pins 5, 10-12 pulled up; GPIO when configured.
`timescale 1ns/1ps
`default_nettype none
module bpfs_top #(
    parameter int NUM_PINS = bpfs_pkg::NUM_PINS
) (
    input wire logic clk_sys,                  // System clock, 125 MHz.
    input wire logic nrst,                     // Synchronous reset, active low.
    input wire logic ce,                       // Clock enable, freezes all state when low.
    input wire logic boot_done,                // Boot completion, level.
    input wire logic cfg_valid,                // Host configuration command strobe.
    input wire logic [3:0] cfg_pin,            // Pin index addressed by the command.
    input wire logic [2:0] cfg_fn,             // Function code requested.
    input wire logic cfg_dout,                 // GPIO output value requested.
    input wire logic cfg_oe,                   // GPIO drive enable requested.
    input wire logic sleep_mode,               // Device sleep state, high asleep.
    input wire logic uart_txd,                 // Serial transmit data from the port.
    input wire logic request_to_send_n,        // Flow-control output from the port.
    input wire logic led_blink_a,              // LED blink source for pin 2.
    input wire logic led_blink_b,              // LED blink source for pin 3.
    input wire logic host_wake_req,            // Host wake request source.
    input wire logic [12:0] pin_in,            // Pad input levels.
    output logic [12:0] pin_out,               // Pad output levels.
    output logic [12:0] pin_oe_n,              // Pad output enables, low drives.
    output logic [12:0] pin_pullup,            // Pad pull-up enables.
    output logic uart_rxd,                     // Serial receive data to the port.
    output logic clear_to_send_n,              // Flow-control input to the port.
    output logic wake_in,                      // Wake-up input to the power logic.
    output logic [12:0] gpio_in,               // Registered pad inputs in GPIO mode.
    output logic booted,                       // Boot routing applied.
    output logic [31:0] default_bit_cycles     // Initial serial bit time in clocks.
);
    // The pin map is fixed, so any other pin count is refused at elaboration.
    if (NUM_PINS != 13) begin : g_bad_pin_count
        $error("bpfs_top serves exactly 13 pins");
    end

    bpfs_pkg::bpfs_state_t state_r, state_nxt;
    logic boot_pulse;
    logic [12:0] spec_out, spec_drive;
    logic [38:0] fn_all;
    logic rx_r, rx_nxt, cts_r, cts_nxt, wake_r, wake_nxt;
    logic [12:0] gin_r, gin_nxt;

    always_comb begin
        state_nxt = state_r;
        boot_pulse = 1'b0;
        case (state_r)
            bpfs_pkg::BPFS_BOOTING: begin
                if (boot_done) begin
                    state_nxt = bpfs_pkg::BPFS_RUN;
                    boot_pulse = 1'b1;
                end
            end
            default: begin
                state_nxt = bpfs_pkg::BPFS_RUN;
            end
        endcase
    end

    always_comb begin
        spec_out = 13'h0000;
        spec_drive = 13'h0000;
        spec_out[bpfs_pkg::PIN_SLEEP_STATE] = sleep_mode;
        spec_drive[bpfs_pkg::PIN_SLEEP_STATE] = 1'b1;
        spec_out[bpfs_pkg::PIN_TX] = uart_txd;
        spec_drive[bpfs_pkg::PIN_TX] = 1'b1;
        spec_out[bpfs_pkg::PIN_RTS] = request_to_send_n;
        spec_drive[bpfs_pkg::PIN_RTS] = 1'b1;
        spec_out[bpfs_pkg::PIN_LED_A] = led_blink_a;
        spec_drive[bpfs_pkg::PIN_LED_A] = 1'b1;
        spec_out[bpfs_pkg::PIN_LED_B] = led_blink_b;
        spec_drive[bpfs_pkg::PIN_LED_B] = 1'b1;
        spec_out[bpfs_pkg::PIN_HOST_WAKE] = host_wake_req;
        spec_drive[bpfs_pkg::PIN_HOST_WAKE] = 1'b1;
    end

    // Boot routes only pins 1, 6, 7, 8 and 9; the rest keep their reset function.
    genvar i;
    generate
        for (i = 0; i < 13; i++) begin : g_pin
            localparam logic [2:0] RST_FN = bpfs_pkg::RESET_FN[3*i +: 3];
            localparam bit AUTO = (i == bpfs_pkg::PIN_SLEEP_STATE) || (i == bpfs_pkg::PIN_TX)
                || (i == bpfs_pkg::PIN_RX) || (i == bpfs_pkg::PIN_RTS)
                || (i == bpfs_pkg::PIN_CTS);
            localparam logic [2:0] BOOT_FN = AUTO ? ((i == bpfs_pkg::PIN_RX
                || i == bpfs_pkg::PIN_CTS) ? bpfs_pkg::FN_SPECIAL : bpfs_pkg::FN_SPECIAL)
                : RST_FN;
            logic we;
            logic boot_hit;
            // Commands take effect only once booted; boot writes auto pins.
            assign we = cfg_valid && (state_r == bpfs_pkg::BPFS_RUN)
                && (cfg_pin == 4'(i));
            assign boot_hit = boot_pulse && AUTO;
            bpfs_pin_sel #(
                .RESET_FN(AUTO ? bpfs_pkg::FN_IN_NOPULL : RST_FN),
                .BOOT_FN(BOOT_FN)
            ) u_sel (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .ce(ce),
                .boot_done(boot_hit),
                .cfg_we(we),
                .cfg_fn(cfg_fn),
                .cfg_dout(cfg_dout),
                .cfg_oe(cfg_oe),
                .spec_out(spec_out[i]),
                .spec_drive(spec_drive[i]),
                .fn(fn_all[3*i +: 3]),
                .pad_out(pin_out[i]),
                .pad_oe_n(pin_oe_n[i]),
                .pad_pullup(pin_pullup[i])
            );
        end
    endgenerate

    always_comb begin
        // Idle the port inputs high so the serial port sees no start bit before boot.
        rx_nxt = 1'b1;
        cts_nxt = 1'b1;
        wake_nxt = 1'b0;
        if (fn_all[3*bpfs_pkg::PIN_RX +: 3] == bpfs_pkg::FN_SPECIAL) begin
            rx_nxt = pin_in[bpfs_pkg::PIN_RX];
        end
        if (fn_all[3*bpfs_pkg::PIN_CTS +: 3] == bpfs_pkg::FN_SPECIAL) begin
            cts_nxt = pin_in[bpfs_pkg::PIN_CTS];
        end
        if (fn_all[3*bpfs_pkg::PIN_WAKE_IN +: 3] == bpfs_pkg::FN_SPECIAL) begin
            wake_nxt = pin_in[bpfs_pkg::PIN_WAKE_IN];
        end
        for (int k = 0; k < 13; k++) begin
            gin_nxt[k] = (fn_all[3*k +: 3] == bpfs_pkg::FN_GPIO) ? pin_in[k] : 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= bpfs_pkg::BPFS_BOOTING;
            rx_r <= 1'b1;
            cts_r <= 1'b1;
            wake_r <= 1'b0;
            gin_r <= 13'h0000;
        end else if (ce) begin
            state_r <= state_nxt;
            rx_r <= rx_nxt;
            cts_r <= cts_nxt;
            wake_r <= wake_nxt;
            gin_r <= gin_nxt;
        end
    end

    assign uart_rxd = rx_r;
    assign clear_to_send_n = cts_r;
    assign wake_in = wake_r;
    assign gpio_in = gin_r;
    assign booted = (state_r == bpfs_pkg::BPFS_RUN);
    assign default_bit_cycles = 32'(bpfs_pkg::DEFAULT_BIT_CYCLES);
endmodule
`default_nettype wire

// *** verif/bpfs_asserts.sv ***
// Port-level checks for the pin function select block.
`timescale 1ns/1ps
`default_nettype none
module bpfs_asserts (
    input wire logic clk_sys, // Clock.
    input wire logic nrst, // Reset.
    input wire logic ce, // Enable.
    input wire logic boot_done, // Boot.
    input wire logic cfg_valid, // Strobe.
    input wire logic [3:0] cfg_pin, // Pin.
    input wire logic [2:0] cfg_fn, // Function.
    input wire logic sleep_mode, // Sleep.
    input wire logic [12:0] pin_in, // Pads in.
    input wire logic [12:0] pin_out, // Pads out.
    input wire logic [12:0] pin_oe_n, // Enables.
    input wire logic [12:0] pin_pullup, // Pull-ups.
    input wire logic uart_rxd, // Receive.
    input wire logic clear_to_send_n, // Flow in.
    input wire logic booted, // Booted.
    input wire logic uart_txd, // Transmit source.
    input wire logic request_to_send_n, // Flow-control source.
    input wire logic [31:0] default_bit_cycles // Bit time.
);
    logic cmd_ok;
    assign cmd_ok = ce && booted && cfg_valid && cfg_pin < 4'hd;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    boot_route_a: assert property (ce && boot_done && !booted |=> booted &&
        !pin_oe_n[1] && !pin_oe_n[6] && !pin_oe_n[8]) else $error("boot routing missing");
    sleep_ind_a: assert property (booted && $past(booted) && $past(ce) |->
        pin_out[1] == $past(sleep_mode)) else $error("sleep indicator wrong");
    rx_cts_a: assert property (booted && $past(booted) && $past(ce) |->
        uart_rxd == $past(pin_in[7]) && clear_to_send_n == $past(pin_in[9])
        && !pin_pullup[7]) else $error("receive routing wrong");
    tx_rts_a: assert property (booted && $past(booted) && $past(ce) |->
        pin_out[6] == $past(uart_txd) && pin_out[8] == $past(request_to_send_n))
        else $error("transmit routing wrong");
    dflt_pads_a: assert property (!booted |-> pin_oe_n == 13'h1fff &&
        pin_pullup == 13'h1c3c) else $error("default pad state wrong");
    cmd_pull_a: assert property (cmd_ok |=>
        pin_pullup[$past(cfg_pin)] == ($past(cfg_fn) == 3'h1)) else $error("pull select wrong");
    spec_drive_a: assert property (cmd_ok && cfg_fn == 3'h3 && cfg_pin > 4'h1 &&
        cfg_pin < 4'h5 |=> !pin_oe_n[$past(cfg_pin)]) else $error("special pin not driven");
    in_mode_a: assert property (cmd_ok && cfg_fn < 3'h2 |=> pin_oe_n[$past(cfg_pin)])
        else $error("input pin driven");
    bit_time_a: assert property (default_bit_cycles == 32'h43d)
        else $error("bit time wrong");
    boot_c: cover property (ce && boot_done && !booted);
    spec_c: cover property (cmd_ok && cfg_fn == 3'h3);
    sleep_c: cover property (booted && sleep_mode);
    gpio_c: cover property (cmd_ok && cfg_fn == 3'h2);
endmodule
bind bpfs_top bpfs_asserts u_chk (.*);
`default_nettype wire

// *** verif/bpfs_host_model.sv ***
// Host-side serial partner: receive data and clear-to-send.
`timescale 1ns/1ps
`default_nettype none
module bpfs_host_model (
    input wire logic clk_sys, // Clock.
    input wire logic send, // Start a frame.
    input wire logic [7:0] data, // Byte to send.
    input wire logic stall, // Host not ready.
    output logic rxd, // Serial data out.
    output logic cts_n // Clear to send.
);
    logic [9:0] frame;
    assign cts_n = stall;
    // The line idles high between frames, as a serial line does.
    always begin
        rxd <= 1'b1;
        @(posedge clk_sys);
        if (send) begin
            frame = {1'b1, data, 1'b0};
            for (int i = 0; i < 10; i++) begin
                rxd <= frame[i];
                repeat (bpfs_pkg::DEFAULT_BIT_CYCLES) @(posedge clk_sys);
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the pin function select block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, boot_done = 1'b0, cfg_valid = 1'b0;
    logic cfg_oe = 1'b0, cfg_dout = 1'b0, sleep_mode = 1'b0, send = 1'b0, stall = 1'b0;
    logic [3:0] cfg_pin = 4'h0;
    logic [2:0] cfg_fn = 3'h0;
    logic [4:0] srcs = 5'h0;
    logic [7:0] data = 8'h0;
    logic [12:0] ext = 13'h0, pin_in, pin_out, pin_oe_n, pin_pullup, snap;
    logic uart_rxd, cts_n, booted, h_rxd, h_cts_n, wake_in;
    logic [12:0] gpio_in, gmask = 13'h0;
    logic [9:0] got;
    logic [31:0] dbc;
    int errors = 0, compares = 0, cycles = 0;
    always #4 clk_sys = ~clk_sys;
    bpfs_top i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .boot_done(boot_done),
        .cfg_valid(cfg_valid), .cfg_pin(cfg_pin), .cfg_fn(cfg_fn), .cfg_dout(cfg_dout),
        .cfg_oe(cfg_oe), .sleep_mode(sleep_mode), .uart_txd(srcs[0]),
        .request_to_send_n(srcs[1]), .led_blink_a(srcs[2]), .led_blink_b(srcs[3]),
        .host_wake_req(srcs[4]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .uart_rxd(uart_rxd), .clear_to_send_n(cts_n),
        .wake_in(wake_in), .gpio_in(gpio_in), .booted(booted), .default_bit_cycles(dbc));
    bpfs_host_model i_host (.clk_sys(clk_sys), .send(send), .data(data), .stall(stall),
        .rxd(h_rxd), .cts_n(h_cts_n));
    // Undriven pads except 7 and 9, fed by the host model, take a random level so a stale value cannot pass.
    always_comb begin
        pin_in = ext;
        pin_in[7] = h_rxd;
        pin_in[9] = h_cts_n;
        for (int i = 0; i < 13; i++) pin_in[i] = pin_oe_n[i] ? pin_in[i] : pin_out[i];
    end
    always @(posedge clk_sys) begin
        srcs <= 5'($urandom);
        ext <= 13'($urandom);
        cycles++;
        if (cycles == 30000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic print_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmd(input logic [3:0] p, input logic [2:0] f, input logic o);
        @(posedge clk_sys);
        cfg_valid <= 1'b1;
        cfg_pin <= p;
        cfg_fn <= f;
        cfg_oe <= o;
        cfg_dout <= ~cfg_dout;
        @(posedge clk_sys);
        cfg_valid <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [1:0] epad(input logic [3:0] p, input logic [2:0] f, input logic o);
        return {f == 3'h1, (f == 3'h2) ? !o : !(f == 3'h3 && p > 4'h1 && p < 4'h5)};
    endfunction
    task automatic chk_dflt();
        for (int p = 0; p < 13; p++) snap[p] = p inside {2, 3, 4, 5, 10, 11, 12};
        chk(pin_pullup, snap);
        chk({booted, pin_oe_n}, 14'h1fff);
        chk({wake_in, gpio_in, uart_rxd, cts_n}, 16'h0003);
    endtask
    initial begin
        logic [3:0] p;
        logic [2:0] f;
        void'($urandom(32'h96cc));
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_dflt();
        cmd(4'h2, 3'h3, 1'b0);
        chk(pin_oe_n[2], 1'b1);
        @(posedge clk_sys);
        boot_done <= 1'b1;
        stall <= 1'b1;
        sleep_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(pin_oe_n & 13'h3c2, 13'h280);
        chk({pin_out[1], cts_n, pin_pullup[7]}, 3'h6);
        @(posedge clk_sys);
        sleep_mode <= 1'b0;
        stall <= 1'b0;
        cmd(4'h4, 3'h3, 1'b0);
        chk({pin_out[1], cts_n, pin_oe_n[4]}, 3'h0);
        chk(dbc, 32'h43d);
        @(posedge clk_sys);
        data <= 8'($urandom);
        send <= 1'b1;
        @(posedge clk_sys);
        send <= 1'b0;
        repeat (bpfs_pkg::DEFAULT_BIT_CYCLES / 2) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            #1;
            got[i] = uart_rxd;
            repeat (bpfs_pkg::DEFAULT_BIT_CYCLES) @(posedge clk_sys);
        end
        chk(got, {1'b1, data, 1'b0});
        for (int n = 0; n < 40; n++) begin
            p = 4'($urandom);
            f = 3'($urandom);
            if (p inside {4'h1, 4'h6, 4'h7, 4'h8, 4'h9}) p = 4'hf;
            snap = pin_oe_n;
            cmd(p, f, cfg_dout);
            if (p < 4'hd) gmask[p] = (f == 3'h2);
            if (p > 4'hc) chk(pin_oe_n, snap);
            else chk({pin_pullup[p], pin_oe_n[p]}, epad(p, f, !cfg_dout));
        end
        cmd(4'h0, 3'h3, 1'b0);
        cmd(4'h5, 3'h2, 1'b0);
        gmask[0] = 1'b0;
        gmask[5] = 1'b1;
        @(posedge clk_sys);
        // Taken at the edge, before any update lands, so it is what the design samples.
        snap = pin_in;
        #1;
        chk(wake_in, snap[0]);
        chk(gpio_in, snap & gmask);
        @(posedge clk_sys);
        ce <= 1'b0;
        cmd(4'h5, 3'h1, 1'b0);
        chk(pin_pullup[5], 1'b0);
        @(posedge clk_sys);
        ce <= 1'b1;
        @(posedge clk_sys);
        nrst <= 1'b0;
        boot_done <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk_dflt();
        print_verdict();
    end
endmodule
`default_nettype wire
